// ---- core/uie_top.sv ----
`timescale 1ns/100ps
`include "uie_defines.svh"
module uie_top #(
    parameter int FRAME_CYC = `UIE_FRAME_NS / `UIE_CLK_NS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Protocol engine events
    input wire logic sof_pulse,
    input wire uie_pkg::uie_txn_type txn,
    // Received line levels
    input wire logic line_dp,
    input wire logic line_dm,
    // Endpoint steering
    output logic buf_set_sel,
    output logic pid_data1,
    output logic handshake_en,
    output logic ep_enabled,
    // Power control
    output logic suspended,
    output logic xcvr_low_power,
    output logic resume_drive
);
    localparam int RST_CYC = (`UIE_RST_NS + `UIE_CLK_NS - 1) / `UIE_CLK_NS;
    // Millisecond counter is 20 bits wide, so the frame length must fit in it
    if (FRAME_CYC < 4 || FRAME_CYC >= (1 << 20)) begin : g_frame_chk
        $error("FRAME_CYC out of range");
    end
    // Address phase accepted by this slave
    function automatic logic bus_take(input logic sel, input logic [1:0] trans, input logic rdy);
        return sel && trans[1] && rdy;
    endfunction
    // ----------------------------------------
    // Line synchroniser
    // ----------------------------------------
    logic [1:0] sync1_ff;
    logic [1:0] line_ff;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync1_ff <= `UIE_LINE_IDLE;
            line_ff <= `UIE_LINE_IDLE;
        end else begin
            sync1_ff <= {line_dp, line_dm};
            line_ff <= sync1_ff;
        end
    end
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic wr_ff, nxt_wr;
    logic [7:0] wa_ff, nxt_wa;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic fs_ff, nxt_fs, lp_ff, nxt_lp, res_ff, nxt_res;
    uie_pkg::uie_flag_type flg_ff, nxt_flg;
    uie_pkg::uie_endpoint_kind_field ep_ff, nxt_ep;
    uie_pkg::uie_state_type st_ff, nxt_st;
    logic [19:0] ms_ff, nxt_ms;
    logic [1:0] miss_ff, nxt_miss;
    logic [15:0] se0_ff, nxt_se0;
    logic bsel_ff, nxt_bsel, pid_ff, nxt_pid, hs_ff, nxt_hs, en_ff, nxt_en;
    logic sus_ff, lpo_ff, rdrv_ff;
    logic tick, is_iso, iso_done, se0_long;
    logic w_ctl, w_st, w_ep;
    assign tick = (ms_ff == 20'(FRAME_CYC - 1));
    assign is_iso = (ep_ff.kind == `UIE_KIND_ISO);
    assign iso_done = txn.done && is_iso && (ep_ff.stat == `UIE_STAT_VALID);
    assign se0_long = (se0_ff >= 16'(RST_CYC));
    assign w_ctl = wr_ff && (wa_ff == `UIE_OFS_CTRL);
    assign w_st = wr_ff && (wa_ff == `UIE_OFS_STAT);
    assign w_ep = wr_ff && (wa_ff == `UIE_OFS_EP);
    // ----------------------------------------
    // Bus slave and registers
    // ----------------------------------------
    always_comb begin
        nxt_wr = bus_take(hsel, htrans, hready) && hwrite;
        nxt_wa = haddr[7:0];
        nxt_hrdata = hrdata_ff;
        if (bus_take(hsel, htrans, hready) && !hwrite) begin
            unique case (haddr[7:0])
                `UIE_OFS_CTRL: nxt_hrdata = {29'h0, res_ff, lp_ff, fs_ff};
                `UIE_OFS_STAT: nxt_hrdata = {25'h0, line_ff, flg_ff};
                `UIE_OFS_EP: nxt_hrdata = {22'h0, bsel_ff, ep_ff};
                default: nxt_hrdata = 32'h0000_0000;
            endcase
        end
        nxt_fs = w_ctl ? hwdata[`UIE_CTL_FORCE_SUSPEND_BIT] : fs_ff;
        nxt_lp = w_ctl ? hwdata[`UIE_CTL_LP] : lp_ff;
        nxt_res = w_ctl ? hwdata[`UIE_CTL_RES] : res_ff;
        nxt_flg = w_st ? (flg_ff & ~uie_pkg::uie_flag_type'(hwdata[4:0])) : flg_ff;
        nxt_ep = ep_ff;
        if (w_ep) begin
            nxt_ep.kind = hwdata[1:0];
            nxt_ep.stat = hwdata[3:2];
            nxt_ep.dir_in = hwdata[4];
            // Toggle-only semantics: writing 1 flips the bit
            nxt_ep.ttog = ep_ff.ttog ^ hwdata[5];
            nxt_ep.rtog = ep_ff.rtog ^ hwdata[6];
            nxt_ep.tcmp = ep_ff.tcmp & ~hwdata[7];
            nxt_ep.rcmp = ep_ff.rcmp & ~hwdata[8];
        end
        // Hardware sets placed after clears so a coincident event wins
        if (iso_done) begin
            if (ep_ff.dir_in) begin
                nxt_ep.tcmp = 1'b1;
                nxt_ep.ttog = nxt_ep.ttog ^ 1'b1;
            end else begin
                nxt_ep.rcmp = 1'b1;
                nxt_ep.rtog = nxt_ep.rtog ^ 1'b1;
            end
            // Status pair deliberately untouched: no flow control
            if (txn.crc_err) begin
                nxt_flg.err = 1'b1;
            end
        end
        if (tick) begin
            nxt_flg.expected_frame_start_event = 1'b1;
        end
        if (tick && !sof_pulse && !fs_ff && miss_ff == 2'h2) begin
            nxt_flg.suspend_request_flag = 1'b1;
        end
        if (st_ff == uie_pkg::UIE_SUSPEND_REQUEST_FLAG && line_ff != `UIE_LINE_IDLE) begin
            nxt_lp = 1'b0;
            nxt_flg.wakeup_flag = 1'b1;
        end
        if (st_ff == uie_pkg::UIE_RESET && line_ff != `UIE_LINE_SE0) begin
            nxt_flg.rst = 1'b1;
        end
        if (st_ff == uie_pkg::UIE_RESET) begin
            // Bus reset returns the CTRL bits and the endpoint register to their power-up values; flags keep theirs
            nxt_fs = 1'b0;
            nxt_lp = 1'b0;
            nxt_res = 1'b0;
            nxt_ep = `UIE_EP_RST;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            fs_ff <= 1'b0;
            lp_ff <= 1'b0;
            res_ff <= 1'b0;
            flg_ff <= `UIE_FLAG_RST;
            ep_ff <= `UIE_EP_RST;
        end else begin
            wr_ff <= nxt_wr;
            wa_ff <= nxt_wa;
            hrdata_ff <= nxt_hrdata;
            fs_ff <= nxt_fs;
            lp_ff <= nxt_lp;
            res_ff <= nxt_res;
            flg_ff <= nxt_flg;
            ep_ff <= nxt_ep;
        end
    end
    // ----------------------------------------
    // Frame monitor and link state
    // ----------------------------------------
    always_comb begin
        nxt_ms = tick ? 20'h0_0000 : ms_ff + 20'h0_0001;
        nxt_miss = miss_ff;
        if (sof_pulse || fs_ff) begin
            nxt_miss = 2'h0;
        end else if (tick && miss_ff != `UIE_MISS_MAX) begin
            nxt_miss = miss_ff + 2'h1;
        end
        nxt_se0 = se0_ff;
        if (line_ff != `UIE_LINE_SE0) begin
            nxt_se0 = 16'h0000;
        end else if (!se0_long) begin
            nxt_se0 = se0_ff + 16'h0001;
        end
        nxt_st = st_ff;
        unique case (st_ff)
            uie_pkg::UIE_RUN: begin
                if (se0_long) begin
                    nxt_st = uie_pkg::UIE_RESET;
                end else if (fs_ff) begin
                    nxt_st = uie_pkg::UIE_SUSPEND_REQUEST_FLAG;
                end
            end
            uie_pkg::UIE_SUSPEND_REQUEST_FLAG: begin
                if (se0_long) begin
                    nxt_st = uie_pkg::UIE_RESET;
                end else if (!fs_ff) begin
                    nxt_st = uie_pkg::UIE_RUN;
                end
            end
            uie_pkg::UIE_RESET: begin
                if (line_ff != `UIE_LINE_SE0) begin
                    nxt_st = uie_pkg::UIE_RUN;
                end
            end
            default: nxt_st = uie_pkg::UIE_RUN;
        endcase
        nxt_bsel = ep_ff.dir_in ? ep_ff.ttog : ep_ff.rtog;
        nxt_pid = is_iso ? 1'b0 : nxt_bsel;
        nxt_hs = !is_iso;
        nxt_en = ep_ff.stat == `UIE_STAT_VALID;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ms_ff <= 20'h0_0000;
            miss_ff <= 2'h0;
            se0_ff <= 16'h0000;
            st_ff <= uie_pkg::UIE_RUN;
            bsel_ff <= 1'b0;
            pid_ff <= 1'b0;
            hs_ff <= 1'b0;
            en_ff <= 1'b0;
            sus_ff <= 1'b0;
            lpo_ff <= 1'b0;
            rdrv_ff <= 1'b0;
        end else begin
            ms_ff <= nxt_ms;
            miss_ff <= nxt_miss;
            se0_ff <= nxt_se0;
            st_ff <= nxt_st;
            bsel_ff <= nxt_bsel;
            pid_ff <= nxt_pid;
            hs_ff <= nxt_hs;
            en_ff <= nxt_en;
            sus_ff <= nxt_st == uie_pkg::UIE_SUSPEND_REQUEST_FLAG;
            lpo_ff <= nxt_lp;
            rdrv_ff <= nxt_res && nxt_fs;
        end
    end
    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign buf_set_sel = bsel_ff;
    assign pid_data1 = pid_ff;
    assign handshake_en = hs_ff;
    assign ep_enabled = en_ff;
    assign suspended = sus_ff;
    assign xcvr_low_power = lpo_ff;
    assign resume_drive = rdrv_ff;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_reset_end;
        st_ff == uie_pkg::UIE_RESET ##1 st_ff == uie_pkg::UIE_RUN;
    endsequence
    rx_toggle_a: assert property (iso_done && !ep_ff.dir_in && !w_ep |=>
        ep_ff.rcmp && ep_ff.rtog != $past(ep_ff.rtog)) else $error("rx toggle");
    iso_stat_a: assert property (iso_done && !w_ep |=> $stable(ep_ff.stat))
        else $error("stat changed");
    out_cmp_a: assert property (iso_done && txn.overrun && !ep_ff.dir_in |=> ep_ff.rcmp)
        else $error("rx complete lost");
    crc_err_a: assert property (iso_done && txn.crc_err |=> flg_ff.err)
        else $error("crc flag");
    iso_pid_a: assert property (is_iso |=> !pid_data1) else $error("pid");
    iso_hs_a: assert property (is_iso |=> !handshake_en) else $error("handshake");
    buf_sel_a: assert property (##1 buf_set_sel ==
        $past(ep_ff.dir_in ? ep_ff.ttog : ep_ff.rtog)) else $error("buffer set");
    suspend_request_flag_req_a: assert property (tick && miss_ff == 2'h2 && !sof_pulse && !fs_ff
        |=> flg_ff.suspend_request_flag) else $error("suspend flag");
    force_mon_a: assert property (fs_ff |=> !$rose(flg_ff.suspend_request_flag))
        else $error("monitor active");
    wake_lp_a: assert property (st_ff == uie_pkg::UIE_SUSPEND_REQUEST_FLAG && line_ff != `UIE_LINE_IDLE
        |=> !lp_ff && flg_ff.wakeup_flag ##1 !xcvr_low_power) else $error("wake");
    rst_flag_a: assert property (s_reset_end |-> flg_ff.rst) else $error("reset flag");
    suspend_request_flag_enter_a: assert property (fs_ff && !se0_long && st_ff == uie_pkg::UIE_RUN
        |=> suspended) else $error("no suspend");
    bus_rst_a: assert property (st_ff == uie_pkg::UIE_RESET
        |=> !fs_ff && !lp_ff && !res_ff && ep_ff == `UIE_EP_RST) else $error("bus reset");
endmodule

// ---- inc/uie_defines.svh ----
`ifndef UIE_DEFINES_SVH
`define UIE_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define UIE_CLK_NS 8
`define UIE_FRAME_NS 1000000
`define UIE_RST_NS 2500
`define UIE_MISS_MAX 2'h3
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UIE_OFS_CTRL 8'h00
`define UIE_OFS_STAT 8'h04
`define UIE_OFS_EP 8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UIE_CTL_FORCE_SUSPEND_BIT 0
`define UIE_CTL_LP 1
`define UIE_CTL_RES 2
`define UIE_ST_LINE 5
`define UIE_EP_SET 9
// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define UIE_KIND_ISO 2'h2
`define UIE_STAT_VALID 2'h3
`define UIE_LINE_IDLE 2'h2
`define UIE_LINE_SE0 2'h0
`define UIE_EP_RST 9'h000
`define UIE_FLAG_RST 5'h00
`endif

// ---- inc/uie_pkg.sv ----
package uie_pkg;
    typedef struct packed {
        logic done;
        logic crc_err;
        logic overrun;
    } uie_txn_type;
    typedef struct packed {
        logic rcmp;
        logic tcmp;
        logic rtog;
        logic ttog;
        logic dir_in;
        logic [1:0] stat;
        logic [1:0] kind;
    } uie_endpoint_kind_field;
    typedef struct packed {
        logic expected_frame_start_event;
        logic err;
        logic rst;
        logic wakeup_flag;
        logic suspend_request_flag;
    } uie_flag_type;
    typedef enum logic [2:0] {
        UIE_RUN = 3'b001,
        UIE_SUSPEND_REQUEST_FLAG = 3'b010,
        UIE_RESET = 3'b100
    } uie_state_type;
endpackage

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`include "uie_defines.svh"
module tb_top;
    localparam int FRAME = 50;
    logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, sof_pulse, line_dp, line_dm;
    logic buf_set_sel, pid_data1, handshake_en, ep_enabled;
    logic suspended, xcvr_low_power, resume_drive;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    uie_pkg::uie_txn_type txn;
    int fail_count = 0;
    int tests_run = 0;
    uie_top #(.FRAME_CYC(FRAME)) i_uie_top (.clk_sys(clk_sys), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sof_pulse(sof_pulse), .txn(txn), .line_dp(line_dp),
        .line_dm(line_dm), .buf_set_sel(buf_set_sel), .pid_data1(pid_data1),
        .handshake_en(handshake_en), .ep_enabled(ep_enabled), .suspended(suspended),
        .xcvr_low_power(xcvr_low_power), .resume_drive(resume_drive));
    uie_host_model i_uie_host_model (.clk_sys(clk_sys), .sof_pulse(sof_pulse),
        .txn(txn), .line_dp(line_dp), .line_dm(line_dm));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Bus master and comparison
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_iso();
        bus(1'b1, `UIE_OFS_EP, 32'h0000000E);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("handshake", 32'h0, 32'(handshake_en));
        chk("pid", 32'h0, 32'(pid_data1));
        chk("enabled", 32'h1, 32'(ep_enabled));
        chk("set0", 32'h0, 32'(buf_set_sel));
        chk("okay resp", 32'h0, 32'(hresp));
        i_uie_host_model.pulse(1'b0, 1'b1, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("set1", 32'h1, 32'(buf_set_sel));
        bus(1'b0, `UIE_OFS_EP, 32'h0);
        chk("ep out", 32'h0000034E, rd);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("err", 32'h1, 32'(rd[3]));
        bus(1'b1, `UIE_OFS_EP, 32'h0000015E);
        i_uie_host_model.pulse(1'b0, 1'b0, 1'b0);
        bus(1'b0, `UIE_OFS_EP, 32'h0);
        chk("ep in", 32'h000002BE, rd);
        // Disabled status: completion must be ignored
        bus(1'b1, `UIE_OFS_EP, 32'h00000012);
        i_uie_host_model.pulse(1'b0, 1'b0, 1'b0);
        bus(1'b0, `UIE_OFS_EP, 32'h0);
        chk("ep off", 32'h000002B2, rd);
        chk("disabled", 32'h0, 32'(ep_enabled));
        $display("test iso done");
    endtask
    task automatic t_suspend_request_flag();
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("line idle", 32'h2, 32'(rd[6:5]));
        bus(1'b1, `UIE_OFS_STAT, 32'h0000001F);
        repeat (8) begin
            i_uie_host_model.pulse(1'b1, 1'b0, 1'b0);
            repeat (30) @(posedge clk_sys);
        end
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("no suspend_request_flag", 32'h0, 32'(rd[0]));
        chk("expected_frame_start_event", 32'h1, 32'(rd[4]));
        repeat (4 * FRAME) @(posedge clk_sys);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("suspend_request_flag", 32'h1, 32'(rd[0]));
        $display("test suspend done");
    endtask
    task automatic t_wake();
        bus(1'b1, `UIE_OFS_CTRL, 32'h1);
        bus(1'b1, `UIE_OFS_STAT, 32'h0000001F);
        bus(1'b1, `UIE_OFS_CTRL, 32'h3);
        repeat (4 * FRAME) @(posedge clk_sys);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("held suspend_request_flag", 32'h0, 32'(rd[0]));
        chk("suspended", 32'h1, 32'(suspended));
        chk("low power", 32'h1, 32'(xcvr_low_power));
        bus(1'b1, `UIE_OFS_CTRL, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("resume", 32'h1, 32'(resume_drive));
        repeat (2 * FRAME) @(posedge clk_sys);
        bus(1'b1, `UIE_OFS_CTRL, 32'h3);
        i_uie_host_model.set_line(2'h1);
        repeat (6) @(posedge clk_sys);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("line k", 32'h1, 32'(rd[6:5]));
        chk("wakeup", 32'h1, 32'(rd[1]));
        bus(1'b0, `UIE_OFS_CTRL, 32'h0);
        chk("lp clear", 32'h1, rd);
        chk("lp pin off", 32'h0, 32'(xcvr_low_power));
        chk("resume off", 32'h0, 32'(resume_drive));
        i_uie_host_model.set_line(2'h0);
        repeat (6) @(posedge clk_sys);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("line se0", 32'h0, 32'(rd[6:5]));
        repeat (400) @(posedge clk_sys);
        i_uie_host_model.set_line(2'h2);
        repeat (6) @(posedge clk_sys);
        bus(1'b0, `UIE_OFS_STAT, 32'h0);
        chk("bus reset", 32'h1, 32'(rd[2]));
        chk("idle again", 32'h2, 32'(rd[6:5]));
        bus(1'b0, `UIE_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("running", 32'h0, 32'(suspended));
        $display("test wake done");
    endtask
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_iso();
        t_suspend_request_flag();
        t_wake();
        conclude();
    end
    // Run needs about 1260 cycles; allow about sixteen times that
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end
endmodule

// ---- test/uie_host_model.sv ----
`timescale 1ns/100ps
module uie_host_model (
    // Clock
    input wire logic clk_sys,
    // Link events
    output logic sof_pulse,
    output uie_pkg::uie_txn_type txn,
    // Line levels, always driven by the host side
    output logic line_dp,
    output logic line_dm
);
    initial begin
        sof_pulse = 1'b0;
        txn = '0;
        line_dp = 1'b1;
        line_dm = 1'b0;
    end
    // ----------------------------------------
    // One-cycle frame start or transaction end
    // ----------------------------------------
    task automatic pulse(input logic sof, input logic crc, input logic ovr);
        @(posedge clk_sys);
        sof_pulse <= sof;
        txn <= '{done: ~sof, crc_err: crc, overrun: ovr};
        @(posedge clk_sys);
        sof_pulse <= 1'b0;
        txn <= '0;
    endtask
    // ----------------------------------------
    // Line pair {dp,dm}: 10 idle, 01 resume, 00 reset
    // ----------------------------------------
    task automatic set_line(input logic [1:0] lv);
        @(posedge clk_sys);
        {line_dp, line_dm} <= lv;
    endtask
endmodule
